// [bench/rtb_bank_test.sv]
`include "rtb_regs.svh"

module rtb_bank_test
    import rtb_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic            i_clk;           // 50 mhz bench clock
    logic            i_rst_n;         // synchronous reset, active low
    rtb_apb_req_type apb;             // apb request driven by the bench
    rtb_apb_rsp_type rsp;             // apb answer from the bank
    logic [8:0]      task_pulse;      // task strobes towards the core
    logic            ready_evt;       // core ready event pulse
    logic            disabled_evt;    // core disabled event pulse
    logic            evt_ready;       // sticky ready level
    logic            evt_disabled;    // sticky disabled level
    logic [31:0]     rd;              // read data of the last transfer
    logic            err;             // slave error of the last transfer
    logic [3:0]      strb;            // byte lanes of the next write
    int              error_cnt;       // mismatches seen
    int              samples_checked; // comparisons made

    rtb_bank u_rtb_bank (
        .i_clk          (i_clk),
        .i_rst_n        (i_rst_n),
        .i_apb          (apb),
        .o_apb          (rsp),
        .o_task         (task_pulse),
        .i_ready_evt    (ready_evt),
        .i_disabled_evt (disabled_evt),
        .o_evt_ready    (evt_ready),
        .o_evt_disabled (evt_disabled)
    );

    // free running clock, 20 ns period
    initial begin
        i_clk = 1'b0;
        forever #10 i_clk = ~i_clk;
    end

    // one comparison, four-state exact
    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; returns at the edge that samples pready
    task automatic apb_xfer(input logic wr, input logic [11:0] addr,
                            input logic [31:0] data);
        int n;
        n = 0;
        @(posedge i_clk);
        apb.psel    <= 1'b1;
        apb.penable <= 1'b0;
        apb.pwrite  <= wr;
        apb.paddr   <= addr;
        apb.pwdata  <= data;
        apb.pstrb   <= strb;
        @(posedge i_clk);
        apb.penable <= 1'b1;
        // bounded wait, the slave decides its own latency
        do begin
            @(posedge i_clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            error_cnt++;
            $display("[ERR] pready expected 1 seen %b", rsp.pready);
        end
        rd = rsp.prdata;
        err = rsp.pslverr;
        apb.psel    <= 1'b0;
        apb.penable <= 1'b0;
    endtask

    // every task offset gives one pulse on its own bit only
    task automatic test_tasks();
        logic [31:0] got;
        for (int n = 0; n < 9; n++) begin
            apb_xfer(1'b1, 12'(4 * n), 32'h0000_0001);
            #1 got = 32'(task_pulse);
            chk("task pulse", 32'(1 << n), got);
            chk("task error", 32'h0, 32'(err));
            @(posedge i_clk);
            #1 chk("task pulse end", 32'h0, 32'(task_pulse));
            apb_xfer(1'b0, 12'(4 * n), 32'h0);
            chk("task read", 32'h0, rd);
        end
    endtask

    // bit 0 clear or unmapped place must not trigger
    task automatic test_refused();
        apb_xfer(1'b1, `RTB_TASK_DISABLE, 32'hffff_fffe);
        #1 chk("zero write pulse", 32'h0, 32'(task_pulse));
        apb_xfer(1'b1, 12'h024, 32'h0000_0001);
        chk("unmapped error", 32'h1, 32'(err));
        #1 chk("unmapped pulse", 32'h0, 32'(task_pulse));
        // lane 0 strobe off: a write of 1 must do nothing
        strb = 4'he;
        apb_xfer(1'b1, `RTB_TASK_START, 32'h0000_0001);
        #1 chk("no strobe pulse", 32'h0, 32'(task_pulse));
        strb = 4'hf;
    endtask

    // event pulse sets a sticky level, readable, cleared by writing 0
    task automatic test_event(input logic sel, input logic [11:0] addr);
        logic [31:0] lvl;
        @(posedge i_clk);
        ready_evt    <= ~sel;
        disabled_evt <= sel;
        @(posedge i_clk);
        ready_evt    <= 1'b0;
        disabled_evt <= 1'b0;
        #1 lvl = 32'(sel ? evt_disabled : evt_ready);
        chk("event level", 32'h1, lvl);
        apb_xfer(1'b0, addr, 32'h0);
        chk("event read", 32'h1, rd);
        apb_xfer(1'b1, addr, 32'h0);
        #1 lvl = 32'(sel ? evt_disabled : evt_ready);
        chk("event clear", 32'h0, lvl);
        apb_xfer(1'b0, addr, 32'h0);
        chk("event read clear", 32'h0, rd);
    endtask

    // verdict, reached from the main flow and the watchdog
    task automatic close_out();
        $display("checks %0d errors %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // watchdog, far beyond the hundred or so cycles the run needs
    initial begin
        #100000;
        error_cnt++;
        close_out();
    end

    // main sequence
    initial begin
        error_cnt       = 0;
        samples_checked = 0;
        i_rst_n         = 1'b0;
        apb             = '0;
        strb            = 4'hf;
        ready_evt       = 1'b0;
        disabled_evt    = 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1 chk("reset pulses", 32'h0, 32'(task_pulse));
        chk("reset events", 32'h0, {30'h0, evt_ready, evt_disabled});
        test_tasks();
        test_refused();
        test_event(1'b0, `RTB_EVT_READY);
        test_event(1'b1, `RTB_EVT_DISABLED);
        close_out();
    end

endmodule

// [design/rtb_bank.sv]
// Overview of operation
// - offset 0x000 write 1 enables transmit
// - offset 0x004 write 1 enables receive
// - offset 0x014 starts one strength sample
// - offset 0x018 stops strength measurement
// - offset 0x01c starts the bit counter
// - offset 0x020 stops the bit counter
// - write-only, bit 0, reset zero, 1 triggers
// - ready event at 0x100 after ramp-up
// - disabled event at 0x110 after disable

`include "rtb_regs.svh"

module rtb_bank
    import rtb_pkg::*;
#(
    parameter int ADDR_W = 12
) (
    // clock and reset
    input  wire logic            i_clk,
    input  wire logic            i_rst_n,
    // apb slave
    input  wire rtb_apb_req_type i_apb,
    output rtb_apb_rsp_type      o_apb,
    // task pulses towards the radio core
    output logic [8:0]           o_task,
    // events from the radio core
    input  wire logic            i_ready_evt,
    input  wire logic            i_disabled_evt,
    // sticky event levels
    output logic                 o_evt_ready,
    output logic                 o_evt_disabled
);

    // the decode below compares twelve address bits
    if (ADDR_W != 12) begin : g_bad_addr
        $error("rtb_bank: ADDR_W must be 12");
    end

    // the whole bank state lives in one struct, so the
    // reset and the register stage cannot drift apart
    rtb_state_type st_q;   // registered state
    rtb_state_type st_d;   // next state

    logic       acc_wr;     // write access phase
    logic       setup_rd;   // read setup cycle
    logic       trig;       // bit 0 written as 1
    logic [8:0] task_hit;   // per task decode
    logic       task_area;  // address in task range
    logic       hit_ready;  // ready event address
    logic       hit_dis;    // disabled event address
    logic       mapped;     // any known register

    // access phase of a write, strobe on lane 0
    assign acc_wr = i_apb.psel && i_apb.penable
                 && i_apb.pwrite && i_apb.pstrb[0];

    // reads are prepared in setup so prdata is a flop
    assign setup_rd = i_apb.psel && !i_apb.penable
                   && !i_apb.pwrite;

    // only the value 1 in bit 0 fires a task
    assign trig = i_apb.pwdata[`RTB_TRIG_BIT]
               == `RTB_TRIG_VALUE;

    // address classification; only bit 0 of a word
    // matters, so byte offsets not a multiple of four are refused
    // as unmapped rather than aliased onto a task
    assign task_area = i_apb.paddr[1:0] == 2'h0
                    && i_apb.paddr <= `RTB_TASK_BC_STOP;
    assign hit_ready = i_apb.paddr == `RTB_EVT_READY;
    assign hit_dis   = i_apb.paddr == `RTB_EVT_DISABLED;
    assign mapped    = task_area || hit_ready || hit_dis;

    // one decoder per task, task n sits at byte 4*n;
    // the range check above keeps offsets past the last
    // task from wrapping onto bits 5:2 of a real one
    for (genvar n = 0; n < `RTB_TASK_COUNT; n++) begin : g_task
        assign task_hit[n] = acc_wr && trig && task_area
            && i_apb.paddr[5:2] == 4'(n);
    end

    // next state
    always_comb begin
        st_d = st_q;
        // pulses last exactly one cycle
        st_d.task_pulse = task_hit;
        // set wins over a software clear: the core event
        // comes last, so a clear in the same cycle loses and
        // software never misses an event it did not see
        // software may clear or set the ready level
        if (acc_wr && hit_ready) begin
            st_d.evt_ready = i_apb.pwdata[0];
        end
        // core reports ramp-up done
        if (i_ready_evt) begin
            st_d.evt_ready = 1'h1;
        end
        // software may clear or set the disabled level
        if (acc_wr && hit_dis) begin
            st_d.evt_disabled = i_apb.pwdata[0];
        end
        // core reports it has shut down
        if (i_disabled_evt) begin
            st_d.evt_disabled = 1'h1;
        end
        // error flag is taken at every setup cycle
        if (i_apb.psel && !i_apb.penable) begin
            st_d.err   = !mapped;
            st_d.rdata = `RTB_TASK_RESET;
        end
        // read data, task registers read zero
        if (setup_rd) begin
            if (hit_ready) begin
                st_d.rdata = {31'h0, st_q.evt_ready};
            end else if (hit_dis) begin
                st_d.rdata = {31'h0, st_q.evt_disabled};
            end else begin
                st_d.rdata = `RTB_TASK_RESET;
            end
        end
    end

    // state register, synchronous reset; only the fields
    // are cleared, so a task pulse can never survive reset
    // and the first write after reset acts normally
    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            st_q.task_pulse   <= 9'h000;
            st_q.evt_ready    <= `RTB_EVT_RESET;
            st_q.evt_disabled <= `RTB_EVT_RESET;
            st_q.rdata        <= `RTB_TASK_RESET;
            st_q.err          <= 1'h0;
        end else begin
            st_q <= st_d;
        end
    end

    // zero wait states: answer in first access cycle;
    // read data was loaded at setup, so prdata is a flop
    // and the access cycle needs no decode in its path
    assign o_apb.pready  = i_apb.psel && i_apb.penable;
    assign o_apb.prdata  = st_q.rdata;
    assign o_apb.pslverr = o_apb.pready && st_q.err;

    // outputs from flops
    assign o_task         = st_q.task_pulse;
    assign o_evt_ready    = st_q.evt_ready;
    assign o_evt_disabled = st_q.evt_disabled;

    // checks: one clock domain, reset quiets them all
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_n);

    // a completed write of 1 to a given offset
    sequence s_trig(logic [11:0] a);
        i_apb.psel && i_apb.penable && i_apb.pwrite
        && i_apb.pstrb[0] && i_apb.pwdata[0]
        && i_apb.paddr == a;
    endsequence

    // the pulse is one cycle wide
    sequence s_one_pulse(int k);
        o_task[k] ##1 !o_task[k];
    endsequence

    chk_tx_en_pulse: assert property (
        s_trig(`RTB_TASK_TX_EN) |=> s_one_pulse(0))
        else $error("transmit enable pulse missing");

    chk_rx_en_pulse: assert property (
        s_trig(`RTB_TASK_RX_EN) |=> o_task[1])
        else $error("receive enable pulse missing");

    chk_ss_start_one: assert property (
        o_task[5] |-> $past(i_apb.paddr) == `RTB_TASK_SS_START
        && $past(acc_wr) && $past(trig) && !$past(o_task[5]))
        else $error("sample start without its write");

    chk_ss_stop_pulse: assert property (
        s_trig(`RTB_TASK_SS_STOP) |=> o_task[6]
        && $onehot(o_task))
        else $error("sample stop pulse wrong");

    chk_bc_start_pulse: assert property (
        s_trig(`RTB_TASK_BC_START) |=> o_task[7])
        else $error("bit counter start missing");

    chk_bc_stop_pulse: assert property (
        s_trig(`RTB_TASK_BC_STOP) |=> o_task[8])
        else $error("bit counter stop missing");

    chk_zero_no_fire: assert property (
        !(acc_wr && trig) |=> o_task == 9'h000)
        else $error("task fired without a 1 write");

    chk_task_read_zero: assert property (
        i_apb.psel && i_apb.penable && !i_apb.pwrite
        && task_area |-> o_apb.prdata == 32'h0)
        else $error("task register read not zero");

    chk_radio_ctl_pulse: assert property (
        s_trig(`RTB_TASK_DISABLE) |=> o_task[4]
        && !o_task[2] && !o_task[3])
        else $error("disable pulse wrong");

    chk_ready_sticky: assert property (
        i_ready_evt |=> o_evt_ready)
        else $error("ready event not captured");

    chk_disabled_set: assert property (
        i_disabled_evt |=> o_evt_disabled)
        else $error("disabled event lost");

    chk_disabled_hold: assert property (
        o_evt_disabled && !(acc_wr && hit_dis)
        |=> o_evt_disabled)
        else $error("disabled event dropped by itself");

    // a completed write of 0 in bit 0 to a given offset
    sequence s_clear(logic [11:0] a);
        i_apb.psel && i_apb.penable && i_apb.pwrite
        && i_apb.pstrb[0] && !i_apb.pwdata[0]
        && i_apb.paddr == a;
    endsequence

    // setup cycle of a read from a given offset
    sequence s_read_setup(logic [11:0] a);
        i_apb.psel && !i_apb.penable && !i_apb.pwrite
        && i_apb.paddr == a;
    endsequence

    // every strobe lasts a single cycle, never two
    chk_rx_en_width: assert property (
        s_trig(`RTB_TASK_RX_EN) |=> s_one_pulse(1))
        else $error("receive enable pulse not one cycle");

    // one write, one sample request: a second cycle doubles it
    chk_ss_start_width: assert property (
        s_trig(`RTB_TASK_SS_START) |=> s_one_pulse(5))
        else $error("sample start pulse not one cycle");

    chk_bc_start_width: assert property (
        s_trig(`RTB_TASK_BC_START) |=> s_one_pulse(7))
        else $error("bit counter start not one cycle");

    chk_bc_stop_width: assert property (
        s_trig(`RTB_TASK_BC_STOP) |=> s_one_pulse(8))
        else $error("bit counter stop not one cycle");

    // radio start, stop and disable each own one strobe
    chk_start_pulse: assert property (
        s_trig(`RTB_TASK_START) |=> s_one_pulse(2))
        else $error("radio start pulse wrong");

    chk_stop_pulse: assert property (
        s_trig(`RTB_TASK_STOP) |=> s_one_pulse(3))
        else $error("radio stop pulse wrong");

    chk_disable_width: assert property (
        s_trig(`RTB_TASK_DISABLE) |=> s_one_pulse(4))
        else $error("radio disable pulse not one cycle");

    // lane 0 off means bit 0 was never written
    chk_strobe_gate: assert property (
        i_apb.psel && i_apb.penable && i_apb.pwrite
        && !i_apb.pstrb[0] |=> o_task == 9'h000)
        else $error("task fired without lane 0 strobe");

    // a single write can only name one task
    chk_pulse_onehot: assert property (
        o_task != 9'h000 |-> $onehot(o_task))
        else $error("more than one task pulse");

    // every pulse goes back to a write of 1 in the task range
    chk_pulse_origin: assert property (
        o_task != 9'h000 |-> $past(acc_wr) && $past(trig)
        && $past(task_area))
        else $error("task pulse without a task write");

    // the ready level stays until software writes it 0
    chk_ready_hold: assert property (
        o_evt_ready && !(acc_wr && hit_ready) |=> o_evt_ready)
        else $error("ready event dropped by itself");

    // a clear with no new event in the same cycle takes effect
    chk_ready_clear: assert property (
        s_clear(`RTB_EVT_READY) ##0 !i_ready_evt |=> !o_evt_ready)
        else $error("ready event not cleared");

    chk_disabled_clear: assert property (
        s_clear(`RTB_EVT_DISABLED) ##0 !i_disabled_evt
        |=> !o_evt_disabled)
        else $error("disabled event not cleared");

    // a read returns the level as it stood at the setup edge
    chk_ready_read: assert property (
        s_read_setup(`RTB_EVT_READY)
        |=> o_apb.prdata == {31'h0, $past(o_evt_ready)})
        else $error("ready event read wrong");

    chk_disabled_read: assert property (
        s_read_setup(`RTB_EVT_DISABLED)
        |=> o_apb.prdata == {31'h0, $past(o_evt_disabled)})
        else $error("disabled event read wrong");

endmodule

// [design/rtb_pkg.sv]
package rtb_pkg;

    // apb request from the master
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
        logic [3:0]  pstrb;
    } rtb_apb_req_type;

    // apb answer to the master
    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } rtb_apb_rsp_type;

    // one pulse per task, index equals offset / 4
    typedef enum logic [3:0] {
        RTB_TX_EN    = 4'h0,
        RTB_RX_EN    = 4'h1,
        RTB_START    = 4'h2,
        RTB_STOP     = 4'h3,
        RTB_DISABLE  = 4'h4,
        RTB_SS_START = 4'h5,
        RTB_SS_STOP  = 4'h6,
        RTB_BC_START = 4'h7,
        RTB_BC_STOP  = 4'h8
    } rtb_task_type;

    // all state of the bank
    typedef struct packed {
        logic [8:0]  task_pulse;
        logic        evt_ready;
        logic        evt_disabled;
        logic [31:0] rdata;
        logic        err;
    } rtb_state_type;

endpackage

// [design/rtb_regs.svh]
`ifndef RTB_REGS_SVH
`define RTB_REGS_SVH

// task trigger offsets, task n at byte 4*n
`define RTB_TASK_TX_EN      12'h000
`define RTB_TASK_RX_EN      12'h004
`define RTB_TASK_START      12'h008
`define RTB_TASK_STOP       12'h00c
`define RTB_TASK_DISABLE    12'h010
`define RTB_TASK_SS_START   12'h014
`define RTB_TASK_SS_STOP    12'h018
`define RTB_TASK_BC_START   12'h01c
`define RTB_TASK_BC_STOP    12'h020

// event registers
`define RTB_EVT_READY       12'h100
`define RTB_EVT_DISABLED    12'h110

// field layout and reset values
`define RTB_TRIG_BIT        0
`define RTB_TRIG_VALUE      1'h1
`define RTB_TASK_RESET      32'h0000_0000
`define RTB_EVT_RESET       1'h0
`define RTB_TASK_COUNT      9

`endif
